/* File: hdl/pccm_monitor.sv */
// Purpose: Port current reading, accumulated charge total and status register map.
// Assumes: The serial engine presents one decoded byte access per request cycle.
// Notes:   Read data and all outputs are registered; reads answer one cycle later.
//
// Behaviour
// - Refresh current reading only while Active
// - Reading is unsigned 8-bit, 11.72 mA steps
// - Clear reading entering Sleep or Detect
// - Clear reading whenever power switch off
// - Total clears only on reset, disable or software clear request
// - Keep charge total when leaving Active
// - Resume accumulating on return if enabled
// - Update charge total once per second
// - Compare new total against rationing threshold
// - Total is 26 bits in field 31:6
// - Four bytes, MSB at lowest address
// - Status registers expose fault and attach flags
// - Undefined addresses read zero, ignore writes
// - Power-on reset loads documented defaults
`timescale 1ns/1ps
module pccm_monitor import pccm_pkg::*; #(
  parameter int UPDATE_CYCLES = PCCM_UPDATE_CYCLES
) (
  input wire logic core_clk, // 10 MHz core clock
  input wire logic sys_rst, // Async power-on reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire pccm_pwr_e pwr_state, // Current device power state
  input wire logic switch_on, // Port power switch is closed
  input wire logic sample_valid, // New port current code present
  input wire logic [7:0] port_current, // Converter code, 11.72 mA per step
  input wire logic rationing_enable, // Charge rationing enabled
  input wire logic rationing_total_clear, // Software request to zero the total
  input wire logic [25:0] rationing_threshold, // Threshold in charge steps
  input wire pccm_stat_s status_in, // Live status bytes from other blocks
  input wire pccm_req_s reg_req, // Register access request
  output logic [7:0] reg_rdata, // Read data, registered
  output logic reg_rvalid, // Read data valid pulse
  output logic [7:0] event_flag_wdata, // Data written to event flag register
  output logic event_flag_wr, // Event flag register write pulse
  output logic overall_rd, // Overall status was read pulse
  output logic [7:0] current_reading, // Port current reading
  output logic [25:0] charge_total_value, // Accumulated charge total
  output logic charge_updated, // Pulse after each total update
  output logic threshold_reached // Total at or above threshold
);

  // ==========================================================================
  // Declarations
  logic [7:0] cur_reg;
  logic [7:0] cur_next;
  pccm_pwr_e pwr_prev_reg;
  pccm_pwr_e pwr_prev_next;
  logic [25:0] chg_reg;
  logic [25:0] chg_next;
  logic upd_reg;
  logic upd_next;
  logic hit_reg;
  logic hit_next;
  logic [25:0] snap_reg;
  logic [25:0] snap_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [7:0] evt_wdata_reg;
  logic [7:0] evt_wdata_next;
  logic evt_wr_reg;
  logic evt_wr_next;
  logic ovr_rd_reg;
  logic ovr_rd_next;
  logic is_active;
  logic entering_idle;
  logic sec_tick;
  logic total_clear;
  logic [26:0] chg_sum;
  logic [31:0] snap_field;

  // ==========================================================================
  // Power state decode
  assign is_active = (pwr_state == PCCM_PWR_ACTIVE);
  assign entering_idle = (pwr_state != pwr_prev_reg) &&
                         ((pwr_state == PCCM_PWR_SLEEP) || (pwr_state == PCCM_PWR_DETECT));

  // Runs only in Active so a fresh second starts on each return
  pccm_sec_tick #(
    .TICK_CYCLES(UPDATE_CYCLES)
  ) u_sec_tick (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .run(is_active),
    .tick(sec_tick)
  );

  // ==========================================================================
  // Current reading
  always_comb begin
    cur_next = cur_reg;
    pwr_prev_next = pwr_state;
    if (!switch_on) begin
      cur_next = PCCM_CURRENT_RST;
    end else if (entering_idle) begin
      cur_next = PCCM_CURRENT_RST;
    end else if (is_active && sample_valid) begin
      cur_next = port_current;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur_reg <= PCCM_CURRENT_RST;
      pwr_prev_reg <= PCCM_PWR_SLEEP;
    end else if (clk_en) begin
      cur_reg <= cur_next;
      pwr_prev_reg <= pwr_prev_next;
    end
  end

  // ==========================================================================
  // Accumulated charge
  // One code held for one second is 11.72 mA*s, about 0.003256 mAh, which is
  // one charge step; adding the raw code per second keeps the scale without a
  // multiplier, at the cost of a 0.17 % under-read.
  assign total_clear = rationing_total_clear || !rationing_enable;
  assign chg_sum = {1'b0, chg_reg} + {19'h0, cur_reg};

  always_comb begin
    chg_next = chg_reg;
    upd_next = 1'b0;
    hit_next = hit_reg;
    if (total_clear) begin
      chg_next = PCCM_CHG_RST;
      hit_next = 1'b0;
    end else if (sec_tick && is_active) begin
      // Saturate rather than wrap so a long session never reads as small
      chg_next = chg_sum[26] ? PCCM_CHG_MAX : chg_sum[25:0];
      upd_next = 1'b1;
    end
    // Leaving Active takes no branch above, so the total is kept
    if (upd_reg && !total_clear) begin
      hit_next = (chg_reg >= rationing_threshold);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      chg_reg <= PCCM_CHG_RST;
      upd_reg <= 1'b0;
      hit_reg <= 1'b0;
    end else if (clk_en) begin
      chg_reg <= chg_next;
      upd_reg <= upd_next;
      hit_reg <= hit_next;
    end
  end

  // ==========================================================================
  // Register port
  // Reading the high byte freezes the whole total, so a four-byte read in
  // address order never mixes values from both sides of an update.
  assign snap_field = {snap_reg, PCCM_CHG_PAD};

  always_comb begin
    snap_next = snap_reg;
    rdata_next = PCCM_UNDEF_RDATA;
    rvalid_next = 1'b0;
    evt_wdata_next = evt_wdata_reg;
    evt_wr_next = 1'b0;
    ovr_rd_next = 1'b0;
    if (reg_req.rd) begin
      rvalid_next = 1'b1;
      unique case (reg_req.addr)
        PCCM_ADDR_CURRENT: begin
          rdata_next = cur_reg;
        end
        PCCM_ADDR_CHG_B3: begin
          snap_next = chg_reg;
          rdata_next = chg_reg[25:18];
        end
        PCCM_ADDR_CHG_B2: begin
          rdata_next = snap_field[23:16];
        end
        PCCM_ADDR_CHG_B1: begin
          rdata_next = snap_field[15:8];
        end
        PCCM_ADDR_CHG_B0: begin
          rdata_next = snap_field[7:0];
        end
        PCCM_ADDR_MISC_FAULT: begin
          rdata_next = status_in.misc_fault;
        end
        PCCM_ADDR_EVENT_FLAG: begin
          rdata_next = status_in.event_flag;
        end
        PCCM_ADDR_OVERALL: begin
          rdata_next = status_in.overall;
          ovr_rd_next = 1'b1;
        end
        PCCM_ADDR_PROFILE_A: begin
          rdata_next = status_in.profile_a;
        end
        PCCM_ADDR_PROFILE_B: begin
          rdata_next = status_in.profile_b;
        end
        PCCM_ADDR_PIN_STATE: begin
          rdata_next = status_in.pin_state;
        end
        default: begin
          rdata_next = PCCM_UNDEF_RDATA;
        end
      endcase
    end else if (reg_req.wr && (reg_req.addr == PCCM_ADDR_EVENT_FLAG)) begin
      // Only the event flag register is writable here; all else is dropped
      evt_wdata_next = reg_req.wdata;
      evt_wr_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_reg <= PCCM_CHG_RST;
      rdata_reg <= PCCM_UNDEF_RDATA;
      rvalid_reg <= 1'b0;
      evt_wdata_reg <= PCCM_UNDEF_RDATA;
      evt_wr_reg <= 1'b0;
      ovr_rd_reg <= 1'b0;
    end else if (clk_en) begin
      snap_reg <= snap_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      evt_wdata_reg <= evt_wdata_next;
      evt_wr_reg <= evt_wr_next;
      ovr_rd_reg <= ovr_rd_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign event_flag_wdata = evt_wdata_reg;
  assign event_flag_wr = evt_wr_reg;
  assign overall_rd = ovr_rd_reg;
  assign current_reading = cur_reg;
  assign charge_total_value = chg_reg;
  assign charge_updated = upd_reg;
  assign threshold_reached = hit_reg;

endmodule : pccm_monitor

/* File: hdl/pccm_pkg.sv */
// Purpose: Shared constants and types for the port current and charge monitor.
// Assumes: 10 MHz core clock; byte-wide register port driven by the serial engine.
// Notes:   Power state codes are supplied by the device state machine outside.
package pccm_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] PCCM_ADDR_CURRENT = 8'h00;
  localparam logic [7:0] PCCM_ADDR_CHG_B3 = 8'h01;
  localparam logic [7:0] PCCM_ADDR_CHG_B2 = 8'h02;
  localparam logic [7:0] PCCM_ADDR_CHG_B1 = 8'h03;
  localparam logic [7:0] PCCM_ADDR_CHG_B0 = 8'h04;
  localparam logic [7:0] PCCM_ADDR_MISC_FAULT = 8'h0F;
  localparam logic [7:0] PCCM_ADDR_EVENT_FLAG = 8'h10;
  localparam logic [7:0] PCCM_ADDR_OVERALL = 8'h11;
  localparam logic [7:0] PCCM_ADDR_PROFILE_A = 8'h12;
  localparam logic [7:0] PCCM_ADDR_PROFILE_B = 8'h13;
  localparam logic [7:0] PCCM_ADDR_PIN_STATE = 8'h14;

  // ==========================================================================
  // Reset values and field layout
  localparam logic [7:0] PCCM_CURRENT_RST = 8'h00;
  localparam logic [7:0] PCCM_UNDEF_RDATA = 8'h00;
  localparam int PCCM_CHG_W = 26;
  localparam logic [25:0] PCCM_CHG_RST = 26'h0000000;
  localparam logic [25:0] PCCM_CHG_MAX = 26'h3FFFFFF;
  localparam int PCCM_CHG_LSB_POS = 6;
  localparam logic [5:0] PCCM_CHG_PAD = 6'h00;
  localparam int PCCM_FULL_SCALE_CODE = 255;

  // ==========================================================================
  // Timing
  localparam int PCCM_CLK_PERIOD_NS = 100;
  localparam int PCCM_UPDATE_PERIOD_MS = 1;
  localparam int PCCM_UPDATE_PERIOD_S = 1;
  localparam int PCCM_UPDATE_CYCLES = PCCM_UPDATE_PERIOD_S * 1000000000 / PCCM_CLK_PERIOD_NS;
  localparam int PCCM_TICK_W = 24;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    PCCM_PWR_SLEEP = 3'h0,
    PCCM_PWR_DETECT = 3'h1,
    PCCM_PWR_ACTIVE = 3'h3,
    PCCM_PWR_ERROR = 3'h2,
    PCCM_PWR_OFF = 3'h6
  } pccm_pwr_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pccm_req_s;

  typedef struct packed {
    logic [7:0] misc_fault;
    logic [7:0] event_flag;
    logic [7:0] overall;
    logic [7:0] profile_a;
    logic [7:0] profile_b;
    logic [7:0] pin_state;
  } pccm_stat_s;

endpackage : pccm_pkg

/* File: hdl/pccm_sec_tick.sv */
// Purpose: One-pulse-per-period prescaler for the charge update.
// Assumes: run is high only while the device is in the Active state.
// Notes:   The count restarts whenever run drops, so a partial interval is dropped.
`timescale 1ns/1ps
module pccm_sec_tick import pccm_pkg::*; #(
  parameter int TICK_CYCLES = PCCM_UPDATE_CYCLES
) (
  input wire logic core_clk, // Core clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic clk_en, // Freezes all state while low
  input wire logic run, // Count only while high
  output logic tick // One-cycle pulse per period
);

  logic [PCCM_TICK_W-1:0] cnt_reg;
  logic [PCCM_TICK_W-1:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // ==========================================================================
  // Period counter
  always_comb begin
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (cnt_reg == PCCM_TICK_W'(TICK_CYCLES - 1)) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + PCCM_TICK_W'(1);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (clk_en) begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : pccm_sec_tick

/* File: tb/pccm_asserts.sv */
// Purpose: Port-level checks for the current and charge monitor.
// Assumes: One clock domain; clk_en drops only while no update is due.
// Notes: Bound into every pccm_monitor instance.
`timescale 1ns/1ps
module pccm_asserts import pccm_pkg::*; #(
  parameter int UPDATE_CYCLES = 20
) (
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic clk_en, // Enable
  input wire pccm_pwr_e pwr_state, // Power state
  input wire logic switch_on, // Switch closed
  input wire logic sample_valid, // Sample strobe
  input wire logic [7:0] port_current, // Sample code
  input wire logic rationing_enable, // Rationing on
  input wire logic rationing_total_clear, // Clear total
  input wire logic [25:0] rationing_threshold, // Threshold
  input wire pccm_req_s reg_req, // Request
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read valid
  input wire logic [7:0] event_flag_wdata, // Flag data
  input wire logic event_flag_wr, // Flag write
  input wire logic [7:0] current_reading, // Reading
  input wire logic [25:0] charge_total_value, // Total
  input wire logic charge_updated, // Update pulse
  input wire logic threshold_reached // Compare flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Cycles since the last update, to bound the update period
  logic [31:0] gap_reg, gap_next;
  always_comb begin
    gap_next = charge_updated ? 32'h0 : gap_reg + 32'h1;
  end
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) gap_reg <= 32'h0;
    else gap_reg <= gap_next;
  end
  // ==========================================================================
  // Checks
  sequence s_rd_undef;
    clk_en && reg_req.rd && reg_req.addr > PCCM_ADDR_PIN_STATE;
  endsequence
  sequence s_update_done;
    charge_updated && rationing_enable && !rationing_total_clear;
  endsequence
  AST_CUR_LOAD: assert property (clk_en && sample_valid && switch_on &&
    pwr_state == PCCM_PWR_ACTIVE |=> current_reading == $past(port_current))
    else $error("reading did not load the sample");
  AST_CUR_HOLD: assert property (clk_en && switch_on && !sample_valid &&
    !(pwr_state inside {PCCM_PWR_SLEEP, PCCM_PWR_DETECT}) |=> $stable(current_reading))
    else $error("reading changed without a sample");
  AST_CUR_SLEEP: assert property (clk_en &&
    pwr_state inside {PCCM_PWR_SLEEP, PCCM_PWR_DETECT} |=> current_reading == 8'h00)
    else $error("reading not cleared in sleep or detect");
  AST_CUR_OFF: assert property (clk_en && !switch_on |=> current_reading == 8'h00)
    else $error("reading not cleared with switch off");
  AST_TOTAL_CLEAR: assert property (clk_en && (rationing_total_clear ||
    !rationing_enable) |=> charge_total_value == 26'h0 && !threshold_reached)
    else $error("total not cleared");
  AST_TOTAL_HOLD: assert property ($changed(charge_total_value) &&
    charge_total_value != 26'h0 |-> charge_updated)
    else $error("total changed outside an update");
  AST_TOTAL_STEP: assert property (charge_updated && $past(rationing_enable) &&
    !$past(rationing_total_clear) |->
    charge_total_value == $past(charge_total_value) + 26'($past(current_reading)))
    else $error("total step wrong");
  AST_TICK_GAP: assert property (charge_updated |-> gap_reg >= UPDATE_CYCLES - 1)
    else $error("updates too close");
  AST_THRESH: assert property (s_update_done |=>
    threshold_reached == ($past(charge_total_value) >= $past(rationing_threshold)))
    else $error("threshold compare wrong");
  AST_RD_UNDEF: assert property (s_rd_undef |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("undefined read not zero");
  AST_CHG_MSB: assert property (clk_en && reg_req.rd && reg_req.addr == 8'h01
    |=> reg_rdata == $past(charge_total_value[25:18]))
    else $error("charge high byte wrong");
  AST_WR_FLAG: assert property (clk_en && reg_req.wr && !reg_req.rd &&
    reg_req.addr == 8'h10 |=> event_flag_wr && event_flag_wdata == $past(reg_req.wdata))
    else $error("flag write not passed on");
  AST_WR_OTHER: assert property (clk_en && reg_req.wr && reg_req.addr != 8'h10
    |=> !event_flag_wr)
    else $error("stray flag write");
endmodule : pccm_asserts
bind pccm_monitor pccm_asserts #(.UPDATE_CYCLES(UPDATE_CYCLES)) chk_u (.core_clk, .sys_rst,
  .clk_en, .pwr_state, .switch_on, .sample_valid, .port_current, .rationing_enable,
  .rationing_total_clear, .rationing_threshold, .reg_req, .reg_rdata, .reg_rvalid,
  .event_flag_wdata, .event_flag_wr, .current_reading, .charge_total_value,
  .charge_updated, .threshold_reached);

/* File: tb/pccm_host.sv */
// Purpose: Host software model issuing byte register accesses.
// Assumes: Answer one cycle after the request is taken.
// Notes: Request held for exactly one taking edge.
`timescale 1ns/1ps
module pccm_host import pccm_pkg::*; (
  input wire logic core_clk, // Clock
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic reg_rvalid, // Read valid
  output pccm_req_s reg_req // Request
);
  initial reg_req = '0;
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] wd,
                        output logic [7:0] d, output logic ok);
    @(posedge core_clk);
    reg_req <= '{rd: rd, wr: !rd, addr: a, wdata: wd};
    @(posedge core_clk);
    reg_req <= '0;
    @(negedge core_clk);
    d = reg_rdata;
    ok = (reg_rvalid === rd);
  endtask : access
endmodule : pccm_host

/* File: tb/port_current_charge_monitor_bench.sv */
// Purpose: Self-checking bench for the current and charge monitor.
// Assumes: Short update period of 20 cycles.
// Notes: Register table first, then hand-written cases.
`timescale 1ns/1ps
module port_current_charge_monitor_bench import pccm_pkg::*;;
  localparam int UPD = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  pccm_pwr_e pwr_state = PCCM_PWR_SLEEP;
  logic switch_on = 1'b0;
  logic sample_valid = 1'b0;
  logic [7:0] port_current = 8'h00;
  logic rationing_enable = 1'b0;
  logic rationing_total_clear = 1'b0;
  logic [25:0] rationing_threshold = 26'h0000070;
  pccm_stat_s status_in = 48'hA1B2C3D4E5F6;
  pccm_req_s reg_req;
  logic [7:0] reg_rdata, event_flag_wdata, current_reading;
  logic reg_rvalid, event_flag_wr, overall_rd, charge_updated, threshold_reached;
  logic [25:0] charge_total_value;
  int bad_count = 0;
  int num_checks = 0;
  // Address beside expected byte
  logic [15:0] rows [15] = '{16'h0000, 16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0FA1,
    16'h10B2, 16'h11C3, 16'h12D4, 16'h13E5, 16'h14F6, 16'h0500, 16'h0E00, 16'h1500, 16'hFF00};
  always #50 core_clk = ~core_clk;
  pccm_monitor #(.UPDATE_CYCLES(UPD)) dut_u (.core_clk, .sys_rst, .clk_en, .pwr_state,
    .switch_on, .sample_valid, .port_current, .rationing_enable, .rationing_total_clear,
    .rationing_threshold, .status_in, .reg_req, .reg_rdata, .reg_rvalid, .event_flag_wdata,
    .event_flag_wr, .overall_rd, .current_reading, .charge_total_value, .charge_updated,
    .threshold_reached);
  pccm_host host_u (.core_clk, .reg_rdata, .reg_rvalid, .reg_req);
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [25:0] got, input logic [25:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host_u.access(1'b1, a, 8'h00, d, ok);
    chk(26'(d), 26'(e));
    chk(26'(ok), 26'h1);
  endtask : rd
  task automatic sample(input logic [7:0] c);
    @(posedge core_clk);
    port_current <= c;
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
  endtask : sample
  task automatic go(input pccm_pwr_e s, input logic sw);
    @(posedge core_clk);
    pwr_state <= s;
    switch_on <= sw;
  endtask : go
  // Bounded wait; a missing update ends the run
  task automatic wait_upd(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (charge_updated !== 1'b1 && n < 200);
    if (charge_updated !== 1'b1) begin
      bad_count++;
      $display("unexpected at %0t: no charge update", $time);
      end_of_test();
    end
  endtask : wait_upd
  // ==========================================================================
  // Sequence
  initial begin
    int n;
    logic [7:0] d;
    logic ok;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 15; i++) rd(rows[i][15:8], rows[i][7:0]);
    go(PCCM_PWR_ACTIVE, 1'b1);
    sample(8'hFF);
    rd(PCCM_ADDR_CURRENT, 8'hFF);
    go(PCCM_PWR_ERROR, 1'b1);
    sample(8'h11);
    rd(PCCM_ADDR_CURRENT, 8'hFF);
    go(PCCM_PWR_ERROR, 1'b0);
    rd(PCCM_ADDR_CURRENT, 8'h00);
    go(PCCM_PWR_ACTIVE, 1'b1);
    sample(8'h22);
    go(PCCM_PWR_DETECT, 1'b1);
    rd(PCCM_ADDR_CURRENT, 8'h00);
    go(PCCM_PWR_ACTIVE, 1'b1);
    rationing_enable <= 1'b1;
    sample(8'h30);
    wait_upd(n);
    chk(charge_total_value, 26'h30);
    wait_upd(n);
    chk(26'(n), 26'(UPD));
    chk(charge_total_value, 26'h60);
    @(negedge core_clk);
    chk(26'(threshold_reached), 26'h0);
    go(PCCM_PWR_SLEEP, 1'b1);
    repeat (30) @(negedge core_clk);
    chk(charge_total_value, 26'h60);
    go(PCCM_PWR_ACTIVE, 1'b1);
    sample(8'h20);
    wait_upd(n);
    chk(charge_total_value, 26'h80);
    @(negedge core_clk);
    chk(26'(threshold_reached), 26'h1);
    go(PCCM_PWR_ERROR, 1'b1);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h20);
    rd(8'h04, 8'h00);
    @(posedge core_clk);
    rationing_total_clear <= 1'b1;
    @(posedge core_clk);
    rationing_total_clear <= 1'b0;
    @(negedge core_clk);
    chk(charge_total_value, 26'h0);
    chk(26'(threshold_reached), 26'h0);
    host_u.access(1'b0, PCCM_ADDR_EVENT_FLAG, 8'h5A, d, ok);
    chk(26'(event_flag_wdata), 26'h5A);
    chk(26'(event_flag_wr), 26'h1);
    host_u.access(1'b0, PCCM_ADDR_MISC_FAULT, 8'hFF, d, ok);
    chk(26'(ok), 26'h1);
    chk(26'(event_flag_wr), 26'h0);
    chk(26'(event_flag_wdata), 26'h5A);
    rd(PCCM_ADDR_MISC_FAULT, 8'hA1);
    chk(26'(overall_rd), 26'h0);
    host_u.access(1'b1, PCCM_ADDR_OVERALL, 8'h00, d, ok);
    chk(26'(overall_rd), 26'h1);
    chk(26'(d), 26'hC3);
    // ========================================================================
    // Frozen enable holds the reading although the switch opens
    @(posedge core_clk);
    clk_en <= 1'b0;
    switch_on <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk(26'(current_reading), 26'h20);
    @(posedge core_clk);
    clk_en <= 1'b1;
    repeat (2) @(negedge core_clk);
    chk(26'(current_reading), 26'h0);
    // ========================================================================
    // Mid-run reset must also drop the held snapshot and flag data
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(26'(event_flag_wdata), 26'h0);
    rd(PCCM_ADDR_CHG_B1, 8'h00);
    end_of_test();
  end
endmodule : port_current_charge_monitor_bench
